// ===== rpa_consts.svh
`ifndef RPA_CONSTS_SVH
`define RPA_CONSTS_SVH

// Register byte offsets
`define RPA_REG_CTRL 12'h000
`define RPA_REG_MF_LEN 12'h004
`define RPA_REG_STATUS 12'h008
`define RPA_REG_LANE_MAP 12'h00c

// Control register fields
`define RPA_CTRL_IGNORE_FCS 0

// Status register field positions
`define RPA_ST_SYNCED 0
`define RPA_ST_LOCK 4
`define RPA_ST_SYNC_ERR 8
`define RPA_ST_PERIOD_ERR 12
`define RPA_ST_REPEAT_ERR 16
`define RPA_ST_FOUND 20
`define RPA_ST_ALIGNED 24
`define RPA_ST_ALIGN_ERR 25
`define RPA_ST_LINK 26
`define RPA_ST_LOCAL_FAULT 27

// Reset values
`define RPA_MF_LEN_RST 16'h3fff

// Block lock: 64 good headers to lock, 16 bad in a 64 window to drop
`define RPA_LOCK_GOOD_M1 7'h3f
`define RPA_LOCK_BAD_M1 5'h0f
`define RPA_SLIP_MAX 4'hf
// Four consecutive invalid markers
`define RPA_REPEAT_M1 2'h3
// Alignment attempts before the failure flag
`define RPA_ALIGN_TRIES_M1 3'h7

// Sync header codes
`define RPA_SH_DATA 2'h1
`define RPA_SH_CTRL 2'h2

// Marker words of the four logical lanes
`define RPA_MARKER_0 64'h90_76_47_00_6f_89_b8_00
`define RPA_MARKER_1 64'hf0_c4_e6_00_0f_3b_19_00
`define RPA_MARKER_2 64'hc5_65_9b_00_3a_9a_64_00
`define RPA_MARKER_3 64'ha2_79_3d_00_5d_86_c2_00

// Frame check
`define RPA_CRC_POLY 32'hedb88320
`define RPA_CRC_INIT 32'hffffffff

`endif

// ===== rpa_pkg.sv
`default_nettype none
package rpa_pkg;

  typedef enum logic [0:0] {
    MK_SEARCH,
    MK_TRACK
  } rpa_mk_e;

  typedef struct packed {
    logic lock;
    logic [6:0] sh_cnt;
    logic [4:0] bad_cnt;
    logic [3:0] slips;
    logic slip;
    rpa_mk_e mk;
    logic [16:0] mf_cnt;
    logic [1:0] rep_cnt;
    logic [1:0] id;
    logic sync_err;
    logic period_err;
    logic repeat_err;
    logic mf_err;
    logic synced;
    logic [3:0] fr_cnt;
    logic fr_valid;
  } rpa_lane_s;

  typedef struct packed {
    rpa_lane_s [3:0] lane;
    logic aligned;
    logic aligned_err;
    logic [2:0] tries;
    logic misaligned;
    logic link_status;
    logic local_fault;
    logic ignore_fcs;
    logic [15:0] mf_len;
    logic [31:0] crc;
    logic pkt_valid;
    logic pkt_sop;
    logic pkt_eop;
    logic pkt_err;
    logic [31:0] pkt_data;
    logic bad_fcs;
    logic [1:0] bad_code;
    logic [31:0] prdata;
    logic pslverr;
  } rpa_state_s;

endpackage
`default_nettype wire

// ===== rpa_lane_align.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpa_consts.svh"

// Summary of operation
// - All status updates on rising core clock
// - Synced low while unlocked or erroring
// - Synced high when locked with markers tracked
// - Sync error on lock failure, loss, no marker
// - Sync and period errors hold until relock or another error
// - Period error on marker at wrong spacing
// - Repeat failure after four invalid markers
// - One-cycle pulse per invalid marker
// - Aligned when all lanes tracked together
// - Alignment error on retries or lost alignment
// - Misaligned pulse when markers not simultaneous
// - Per-lane header error count with valid
// - Two-bit logical lane id per position
// - Found bit once logical lane identified
// - Block lock per standard header procedure
// - Link status is aligned and not high-error
// - Local fault is OR of two faults
// - Flag computed versus carried CRC mismatch
// - Packet error on last transfer unless ignored
// - One-cycle bad frame check pulse per error
// - Two-bit bad code: registered decode error state in low bit, high bit zero
module rpa_lane_align (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [3:0] i_lane_valid,
  input wire logic [3:0][1:0] i_lane_hdr,
  input wire logic [3:0][63:0] i_lane_data,
  input wire logic i_high_error_rate,
  input wire logic i_received_local_fault,
  input wire logic i_internal_local_fault,
  input wire logic i_decode_err_state,
  input wire logic i_pkt_valid,
  input wire logic i_pkt_sop,
  input wire logic i_pkt_eop,
  input wire logic [31:0] i_pkt_data,
  output logic [3:0] o_lane_slip,
  output logic [3:0] o_synced,
  output logic [3:0] o_sync_error,
  output logic [3:0] o_marker_period_error,
  output logic [3:0] o_marker_repeat_failure,
  output logic [3:0] o_marker_invalid_pulse,
  output logic [3:0] o_block_lock,
  output logic [3:0] o_logical_lane_found,
  output logic [3:0][1:0] o_logical_lane_id,
  output logic [3:0][3:0] o_framing_err_cnt,
  output logic [3:0] o_framing_err_valid,
  output logic o_aligned,
  output logic o_aligned_err,
  output logic o_misaligned,
  output logic o_link_status,
  output logic o_local_fault,
  output logic o_pkt_valid,
  output logic o_pkt_sop,
  output logic o_pkt_eop,
  output logic o_pkt_err,
  output logic [31:0] o_pkt_data,
  output logic o_bad_fcs,
  output logic [1:0] o_bad_code
);
  import rpa_pkg::*;

  rpa_state_s st;
  rpa_state_s next_st;

  // Reflected CRC32, data taken least significant bit first
  function automatic logic [31:0] crc32_word(input logic [31:0] crc, input logic [31:0] data);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 32; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ `RPA_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

  // Returns {hit, logical lane index} for a control block carrying a marker
  function automatic logic [2:0] marker_match(input logic [1:0] hdr, input logic [63:0] data);
    logic [2:0] r;
    r = 3'h0;
    if (hdr == `RPA_SH_CTRL) begin
      if (data == `RPA_MARKER_0) r = 3'h4;
      if (data == `RPA_MARKER_1) r = 3'h5;
      if (data == `RPA_MARKER_2) r = 3'h6;
      if (data == `RPA_MARKER_3) r = 3'h7;
    end
    return r;
  endfunction

  function automatic logic [31:0] status_word(input rpa_state_s s);
    logic [31:0] w;
    w = 32'h0;
    for (int l = 0; l < 4; l++) begin
      w[`RPA_ST_SYNCED + l] = s.lane[l].synced;
      w[`RPA_ST_LOCK + l] = s.lane[l].lock;
      w[`RPA_ST_SYNC_ERR + l] = s.lane[l].sync_err;
      w[`RPA_ST_PERIOD_ERR + l] = s.lane[l].period_err;
      w[`RPA_ST_REPEAT_ERR + l] = s.lane[l].repeat_err;
      w[`RPA_ST_FOUND + l] = (s.lane[l].mk == MK_TRACK);
    end
    w[`RPA_ST_ALIGNED] = s.aligned;
    w[`RPA_ST_ALIGN_ERR] = s.aligned_err;
    w[`RPA_ST_LINK] = s.link_status;
    w[`RPA_ST_LOCAL_FAULT] = s.local_fault;
    return w;
  endfunction

  always_comb begin
    rpa_lane_s ln;
    logic bad;
    logic [2:0] mm;
    logic at_slot;
    logic any_mk;
    logic all_mk;
    logic all_synced;
    logic [31:0] crc_cur;
    logic mismatch;
    ln = '0;
    bad = 1'b0;
    mm = 3'h0;
    at_slot = 1'b0;
    any_mk = 1'b0;
    all_mk = 1'b1;
    all_synced = 1'b1;
    crc_cur = 32'h0;
    mismatch = 1'b0;
    next_st = st;
    next_st.misaligned = 1'b0;
    next_st.bad_fcs = 1'b0;

    for (int l = 0; l < 4; l++) begin
      ln = st.lane[l];
      ln.mf_err = 1'b0;
      ln.slip = 1'b0;
      ln.fr_valid = i_lane_valid[l];
      ln.fr_cnt = 4'h0;
      if (i_lane_valid[l]) begin
        bad = (i_lane_hdr[l] != `RPA_SH_DATA) && (i_lane_hdr[l] != `RPA_SH_CTRL);
        ln.fr_cnt = {3'h0, bad};
        mm = marker_match(i_lane_hdr[l], i_lane_data[l]);
        if (!st.lane[l].lock) begin
          // Hunting: any bad header restarts the count and slips one bit
          if (bad) begin
            ln.sh_cnt = 7'h0;
            ln.slip = 1'b1;
            if (ln.slips == `RPA_SLIP_MAX) begin
              ln.slips = 4'h0;
              ln.sync_err = 1'b1;
              ln.period_err = 1'b0;
              ln.repeat_err = 1'b0;
            end else begin
              ln.slips = ln.slips + 4'h1;
            end
          end else if (ln.sh_cnt == `RPA_LOCK_GOOD_M1) begin
            ln.lock = 1'b1;
            ln.sh_cnt = 7'h0;
            ln.bad_cnt = 5'h0;
            ln.slips = 4'h0;
            ln.sync_err = 1'b0;
            ln.period_err = 1'b0;
            ln.repeat_err = 1'b0;
            ln.mk = MK_SEARCH;
            ln.mf_cnt = 17'h0;
            ln.rep_cnt = 2'h0;
          end else begin
            ln.sh_cnt = ln.sh_cnt + 7'h1;
          end
        end else if (bad && (ln.bad_cnt == `RPA_LOCK_BAD_M1)) begin
          // Too many header errors in one window: lock is lost
          ln.lock = 1'b0;
          ln.sh_cnt = 7'h0;
          ln.bad_cnt = 5'h0;
          ln.sync_err = 1'b1;
          ln.period_err = 1'b0;
          ln.repeat_err = 1'b0;
          ln.mk = MK_SEARCH;
        end else begin
          if (bad) begin
            ln.bad_cnt = ln.bad_cnt + 5'h1;
          end
          if (ln.sh_cnt == `RPA_LOCK_GOOD_M1) begin
            ln.sh_cnt = 7'h0;
            ln.bad_cnt = 5'h0;
          end else begin
            ln.sh_cnt = ln.sh_cnt + 7'h1;
          end
          // Marker tracking only runs while locked
          case (ln.mk)
            MK_SEARCH: begin
              if (mm[2]) begin
                ln.mk = MK_TRACK;
                ln.id = mm[1:0];
                ln.mf_cnt = 17'h0;
                ln.rep_cnt = 2'h0;
              end else if (ln.mf_cnt == {st.mf_len, 1'b0}) begin
                // Two whole periods without a marker
                ln.mf_cnt = 17'h0;
                ln.sync_err = 1'b1;
                ln.period_err = 1'b0;
                ln.repeat_err = 1'b0;
              end else begin
                ln.mf_cnt = ln.mf_cnt + 17'h1;
              end
            end
            MK_TRACK: begin
              at_slot = (ln.mf_cnt + 17'h1) == {1'b0, st.mf_len};
              if (at_slot) begin
                ln.mf_cnt = 17'h0;
                if (mm[2]) begin
                  ln.rep_cnt = 2'h0;
                  any_mk = 1'b1;
                end else begin
                  ln.mf_err = 1'b1;
                  if (ln.rep_cnt == `RPA_REPEAT_M1) begin
                    ln.repeat_err = 1'b1;
                    ln.sync_err = 1'b0;
                    ln.period_err = 1'b0;
                    ln.mk = MK_SEARCH;
                  end else begin
                    ln.rep_cnt = ln.rep_cnt + 2'h1;
                  end
                end
              end else if (mm[2]) begin
                // Marker seen off the expected spacing
                ln.period_err = 1'b1;
                ln.sync_err = 1'b0;
                ln.repeat_err = 1'b0;
                ln.mk = MK_SEARCH;
                ln.mf_cnt = 17'h0;
              end else begin
                ln.mf_cnt = ln.mf_cnt + 17'h1;
              end
            end
            default: begin
              ln.mk = MK_SEARCH;
            end
          endcase
        end
      end
      // A marker counts as present only on a lane that hit its slot with one
      if (!(i_lane_valid[l] && st.lane[l].lock && (st.lane[l].mk == MK_TRACK) && at_slot
            && mm[2])) begin
        all_mk = 1'b0;
      end
      at_slot = 1'b0;
      ln.synced = ln.lock && (ln.mk == MK_TRACK) &&
                  !(ln.sync_err || ln.period_err || ln.repeat_err);
      all_synced = all_synced && ln.synced;
      next_st.lane[l] = ln;
    end

    // Alignment: no deskew buffer here, markers must already arrive together
    if (!all_synced) begin
      if (st.aligned) begin
        next_st.aligned_err = 1'b1;
      end
      next_st.aligned = 1'b0;
      next_st.tries = 3'h0;
    end else if (any_mk) begin
      if (all_mk) begin
        next_st.aligned = 1'b1;
        next_st.aligned_err = 1'b0;
        next_st.tries = 3'h0;
      end else begin
        next_st.misaligned = 1'b1;
        if (st.aligned) begin
          next_st.aligned = 1'b0;
          next_st.aligned_err = 1'b1;
        end else if (st.tries == `RPA_ALIGN_TRIES_M1) begin
          next_st.aligned_err = 1'b1;
        end else begin
          next_st.tries = st.tries + 3'h1;
        end
      end
    end
    next_st.link_status = next_st.aligned && !i_high_error_rate;
    next_st.local_fault = i_received_local_fault || i_internal_local_fault;
    next_st.bad_code = {1'b0, i_decode_err_state};

    // Frame check: last word of each packet carries the CRC
    next_st.pkt_valid = i_pkt_valid;
    next_st.pkt_sop = i_pkt_sop;
    next_st.pkt_eop = i_pkt_eop;
    next_st.pkt_data = i_pkt_data;
    next_st.pkt_err = 1'b0;
    if (i_pkt_valid) begin
      crc_cur = i_pkt_sop ? `RPA_CRC_INIT : st.crc;
      if (i_pkt_eop) begin
        mismatch = ~crc_cur != i_pkt_data;
        next_st.bad_fcs = mismatch;
        next_st.pkt_err = mismatch && !st.ignore_fcs;
        next_st.crc = `RPA_CRC_INIT;
      end else begin
        next_st.crc = crc32_word(crc_cur, i_pkt_data);
      end
    end

    // APB: read data and error decided in setup, presented in access
    if (i_psel && !i_penable) begin
      next_st.pslverr = 1'b0;
      case (i_paddr)
        `RPA_REG_CTRL: next_st.prdata = {31'h0, st.ignore_fcs};
        `RPA_REG_MF_LEN: next_st.prdata = {16'h0, st.mf_len};
        `RPA_REG_STATUS: next_st.prdata = status_word(st);
        `RPA_REG_LANE_MAP: next_st.prdata = {24'h0, st.lane[3].id, st.lane[2].id,
                                             st.lane[1].id, st.lane[0].id};
        default: begin
          next_st.prdata = 32'h0;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    if (i_psel && i_penable && i_pwrite && !st.pslverr) begin
      case (i_paddr)
        `RPA_REG_CTRL: begin
          if (i_pstrb[0]) next_st.ignore_fcs = i_pwdata[`RPA_CTRL_IGNORE_FCS];
        end
        `RPA_REG_MF_LEN: begin
          if (i_pstrb[0]) next_st.mf_len[7:0] = i_pwdata[7:0];
          if (i_pstrb[1]) next_st.mf_len[15:8] = i_pwdata[15:8];
        end
        default: begin
          next_st.ignore_fcs = next_st.ignore_fcs;
        end
      endcase
    end

    if (i_sys_rst) begin
      next_st = '0;
      next_st.mf_len = `RPA_MF_LEN_RST;
      next_st.crc = `RPA_CRC_INIT;
    end
  end

  always_ff @(posedge i_core_clk) begin
    st <= next_st;
  end

  always_comb begin
    for (int l = 0; l < 4; l++) begin
      o_lane_slip[l] = st.lane[l].slip;
      o_synced[l] = st.lane[l].synced;
      o_sync_error[l] = st.lane[l].sync_err;
      o_marker_period_error[l] = st.lane[l].period_err;
      o_marker_repeat_failure[l] = st.lane[l].repeat_err;
      o_marker_invalid_pulse[l] = st.lane[l].mf_err;
      o_block_lock[l] = st.lane[l].lock;
      o_logical_lane_found[l] = (st.lane[l].mk == MK_TRACK);
      o_logical_lane_id[l] = st.lane[l].id;
      o_framing_err_cnt[l] = st.lane[l].fr_cnt;
      o_framing_err_valid[l] = st.lane[l].fr_valid;
    end
  end

  assign o_prdata = st.prdata;
  assign o_pslverr = st.pslverr && i_psel && i_penable;
  assign o_pready = i_psel && i_penable;
  assign o_aligned = st.aligned;
  assign o_aligned_err = st.aligned_err;
  assign o_misaligned = st.misaligned;
  assign o_link_status = st.link_status;
  assign o_local_fault = st.local_fault;
  assign o_pkt_valid = st.pkt_valid;
  assign o_pkt_sop = st.pkt_sop;
  assign o_pkt_eop = st.pkt_eop;
  assign o_pkt_err = st.pkt_err;
  assign o_pkt_data = st.pkt_data;
  assign o_bad_fcs = st.bad_fcs;
  assign o_bad_code = st.bad_code;

endmodule
`default_nettype wire

// ===== rpa_lane_align_props.sv
`timescale 1ns/1ps
`default_nettype none
module rpa_lane_align_props (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_lane_valid,
  input wire logic i_high_error_rate,
  input wire logic i_received_local_fault,
  input wire logic i_internal_local_fault,
  input wire logic i_decode_err_state,
  input wire logic i_pkt_valid,
  input wire logic i_pkt_eop,
  input wire logic [3:0] o_synced,
  input wire logic [3:0] o_sync_error,
  input wire logic [3:0] o_marker_period_error,
  input wire logic [3:0] o_marker_repeat_failure,
  input wire logic [3:0] o_marker_invalid_pulse,
  input wire logic [3:0] o_block_lock,
  input wire logic [3:0] o_framing_err_valid,
  input wire logic o_aligned,
  input wire logic o_aligned_err,
  input wire logic o_misaligned,
  input wire logic o_link_status,
  input wire logic o_local_fault,
  input wire logic o_pkt_eop,
  input wire logic o_pkt_err,
  input wire logic o_bad_fcs,
  input wire logic [1:0] o_bad_code
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_synced_clean: assert property (
    (o_synced & (o_sync_error | o_marker_period_error | o_marker_repeat_failure | ~o_block_lock))
    == 4'h0) else $error("synced lane with fault");
  a_invalid_locked: assert property (!$past(i_sys_rst) |->
    (o_marker_invalid_pulse & ~$past(o_block_lock)) == 4'h0) else $error("marker pulse unlocked");
  a_rise_aligned: assert property ($rose(o_aligned) |->
    $past(o_synced) == 4'hf && !o_aligned_err) else $error("aligned without lanes");
  a_lost_aligned: assert property (!$past(i_sys_rst) && $fell(o_aligned) |->
    ##[0:1] o_aligned_err) else $error("alignment loss unflagged");
  a_link_up: assert property (o_aligned && $past(o_aligned) && !$past(i_high_error_rate)
    |-> o_link_status) else $error("link down while aligned");
  a_link_down: assert property ($past(i_high_error_rate) |-> !o_link_status)
    else $error("link up with high error rate");
  a_fault_level: assert property (!$past(i_sys_rst) |->
    o_local_fault == $past(i_received_local_fault || i_internal_local_fault))
    else $error("local fault mismatch");
  a_code_count: assert property (!$past(i_sys_rst) |->
    o_bad_code == {1'b0, $past(i_decode_err_state)}) else $error("bad code mismatch");
  a_fcs_on_eop: assert property (o_bad_fcs |->
    o_pkt_eop && $past(i_pkt_valid && i_pkt_eop)) else $error("fcs pulse off eop");
  a_err_needs_fcs: assert property (o_pkt_err |-> o_bad_fcs && o_pkt_eop)
    else $error("packet error without fcs");
  a_err_valid: assert property (!$past(i_sys_rst) |->
    o_framing_err_valid == $past(i_lane_valid)) else $error("framing valid mismatch");
  a_misalign_pulse: assert property (o_misaligned |=> !o_misaligned)
    else $error("misaligned not a pulse");
  c_aligned: cover property ($rose(o_aligned));
  c_align_err: cover property ($rose(o_aligned_err));
  c_repeat: cover property (o_marker_repeat_failure != 4'h0);
  c_pkt_err: cover property (o_pkt_err);
endmodule
bind rpa_lane_align rpa_lane_align_props i_props (.*);
`default_nettype wire

// ===== rpa_far_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpa_consts.svh"
module rpa_far_tx (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_stall,
  input wire logic [4:0] i_period,
  input wire logic [3:0] i_drop,
  input wire logic [3:0] i_bad_hdr,
  input wire logic [3:0][1:0] i_map,
  output logic [3:0] o_valid,
  output logic [3:0][1:0] o_hdr,
  output logic [3:0][63:0] o_data
);
  logic [4:0] slot;
  logic [7:0] blk;
  logic [63:0] mk [4];
  initial begin
    mk = '{`RPA_MARKER_0, `RPA_MARKER_1, `RPA_MARKER_2, `RPA_MARKER_3};
    o_valid = 4'h0;
    o_hdr = '0;
    o_data = '0;
    blk = 8'h0;
  end
  // Idle data toggles so a stale word never passes for a fresh one
  always @(posedge i_clk) begin
    o_valid <= {4{!i_rst && !i_stall}};
    if (i_rst)
      slot <= 5'h0;
    if (i_rst || i_stall) begin
      o_data <= ~o_data;
    end else begin
      slot <= (slot >= i_period - 5'h1) ? 5'h0 : slot + 5'h1;
      blk <= blk + 8'h1;
      for (int l = 0; l < 4; l++) begin
        o_hdr[l] <= i_bad_hdr[l] ? 2'h0 :
                    (slot == 5'h0 && !i_drop[l]) ? `RPA_SH_CTRL : `RPA_SH_DATA;
        o_data[l] <= (slot == 5'h0 && !i_drop[l]) ? mk[i_map[l]] : {8{blk}};
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpa_consts.svh"
module tb_top;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, o_pready, o_pslverr, se;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0, o_prdata, i_pkt_data = 32'h0, o_pkt_data, rd;
  logic [3:0] i_pstrb = 4'h0, i_lane_valid, o_lane_slip, o_synced, o_sync_error, o_block_lock;
  logic [3:0] o_marker_period_error, o_marker_repeat_failure, o_marker_invalid_pulse;
  logic [3:0] o_logical_lane_found, o_framing_err_valid, drop = 4'h0, bad = 4'h0;
  logic [3:0][1:0] i_lane_hdr, o_logical_lane_id;
  logic [3:0][1:0] map = {2'h1, 2'h0, 2'h3, 2'h2};
  logic [3:0][63:0] i_lane_data;
  logic [3:0][3:0] o_framing_err_cnt;
  logic i_high_error_rate = 1'b0, i_received_local_fault = 1'b0, i_internal_local_fault = 1'b0;
  logic i_decode_err_state = 1'b0, i_pkt_valid = 1'b0, i_pkt_sop = 1'b0, i_pkt_eop = 1'b0;
  logic o_aligned, o_aligned_err, o_misaligned, o_link_status, o_local_fault, o_pkt_valid;
  logic o_pkt_sop, o_pkt_eop, o_pkt_err, o_bad_fcs, stall = 1'b0;
  logic [1:0] o_bad_code;
  logic [4:0] period = 5'h8;
  logic [31:0] pq[$];
  logic [1:0] eq[$];
  logic [3:0] hq = 4'h0, lq = 4'h0;
  logic [3:0][3:0] fq = '0;
  integer seed = 32'hadeb, n_errors = 0, checks_done = 0, k = 0, fcs_n = 0, err_n = 0;
  integer inv_n = 0, mis_n = 0;
  rpa_far_tx i_far (
    .i_clk(i_core_clk),
    .i_rst(i_sys_rst),
    .i_stall(stall),
    .i_period(period),
    .i_drop(drop),
    .i_bad_hdr(bad),
    .i_map(map),
    .o_valid(i_lane_valid),
    .o_hdr(i_lane_hdr),
    .o_data(i_lane_data)
  );
  rpa_lane_align i_dut (.*);
  always #10 i_core_clk = ~i_core_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic step();
    @(negedge i_core_clk);
    k++;
  endtask
  task automatic tmo();
    if (k >= 3000) begin
      n_errors++;
      results();
    end else begin
      k = 0;
    end
  endtask
  task automatic align_wait();
    while (o_aligned !== 1'b1 && k < 3000) step();
    tmo();
    @(negedge i_core_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= 4'hf;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    k = (o_pready === 1'b1) ? 0 : 3000;
    tmo();
    rd = o_prdata;
    se = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // Reference frame check kept bitwise on purpose, independent of the design
  task automatic pkt(input int n, input logic flip);
    logic [31:0] c, w;
    c = `RPA_CRC_INIT;
    for (int i = 0; i <= n; i++) begin
      @(posedge i_core_clk);
      w = (i == n) ? ~c ^ 32'(flip) : 32'($random(seed));
      for (int b = 0; b < 32; b++) c = (c >> 1) ^ ((c[0] ^ w[b]) ? `RPA_CRC_POLY : 32'h0);
      i_pkt_valid <= 1'b1;
      i_pkt_sop <= i == 0;
      i_pkt_eop <= i == n;
      i_pkt_data <= w;
      pq.push_back(w);
      eq.push_back({i == 0, i == n});
    end
    @(posedge i_core_clk);
    i_pkt_valid <= 1'b0;
    i_pkt_sop <= 1'b0;
    i_pkt_eop <= 1'b0;
  endtask
  task automatic rst_chk();
    @(negedge i_core_clk);
    chk("rst", 32'({o_synced, o_block_lock, o_sync_error, o_aligned, o_local_fault}), 32'h0);
    apb(1'b0, `RPA_REG_MF_LEN, 32'h0);
    chk("mf_len rst", rd, 32'h3fff);
  endtask
  always @(posedge i_core_clk) begin
    stall <= 3'($random(seed)) == 3'h0;
    {i_decode_err_state, i_received_local_fault, i_internal_local_fault} <= 3'($random(seed));
  end
  always @(negedge i_core_clk) begin
    if (!i_sys_rst) begin
      fcs_n += o_bad_fcs;
      err_n += o_pkt_err;
      inv_n += o_marker_invalid_pulse[0];
      mis_n += o_misaligned;
      chk("framing cnt", 32'(o_framing_err_cnt), 32'(fq));
      chk("slip", 32'(o_lane_slip), 32'(hq & ~lq));
      if (o_pkt_valid === 1'b1) begin
        chk("pkt data", o_pkt_data, pq.pop_front());
        chk("pkt flags", 32'({o_pkt_sop, o_pkt_eop}), 32'(eq.pop_front()));
      end
    end
    // Model of the per-block header error count, one cycle behind the lanes
    for (int l = 0; l < 4; l++) begin
      hq[l] = i_lane_valid[l] && !(i_lane_hdr[l] inside {`RPA_SH_DATA, `RPA_SH_CTRL});
      fq[l] = {3'h0, hq[l]};
    end
    lq = o_block_lock;
  end
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rst_chk();
    apb(1'b1, `RPA_REG_MF_LEN, 32'h8);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", rd | 32'(se), 32'h1);
    align_wait();
    chk("lock", 32'(o_block_lock), 32'hf);
    chk("synced", 32'(o_synced), 32'hf);
    chk("found", 32'(o_logical_lane_found), 32'hf);
    chk("lane id", 32'(o_logical_lane_id), 32'(map));
    chk("link", 32'(o_link_status), 32'h1);
    apb(1'b0, `RPA_REG_STATUS, 32'h0);
    chk("status", rd & 32'h07ff_ffff, 32'h05f0_00ff);
    apb(1'b0, `RPA_REG_LANE_MAP, 32'h0);
    chk("map reg", rd, 32'(map));
    @(posedge i_core_clk);
    i_high_error_rate <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk("link hber", 32'(o_link_status), 32'h0);
    @(posedge i_core_clk);
    i_high_error_rate <= 1'b0;
    pkt(4, 1'b0);
    pkt(6, 1'b1);
    apb(1'b1, `RPA_REG_CTRL, 32'h1);
    pkt(1, 1'b1);
    pkt(0, 1'b0);
    repeat (3) @(negedge i_core_clk);
    chk("bad fcs", fcs_n, 32'h2);
    chk("pkt err", err_n, 32'h1);
    @(posedge i_core_clk);
    inv_n = 0;
    mis_n = 0;
    drop <= 4'h1;
    while (o_marker_repeat_failure[0] !== 1'b1 && k < 3000) step();
    tmo();
    chk("synced0", 32'(o_synced[0]), 32'h0);
    repeat (2) @(negedge i_core_clk);
    chk("invalid n", inv_n, 32'h4);
    chk("align err", 32'({o_aligned, o_aligned_err}), 32'h1);
    chk("misaligned", 32'(mis_n > 0), 32'h1);
    @(posedge i_core_clk);
    drop <= 4'h0;
    // Marker errors hold until relock or another marker error, so recovery waits for the header burst
    @(posedge i_core_clk);
    period <= 5'h9;
    while (o_marker_period_error === 4'h0 && k < 3000) step();
    tmo();
    chk("period", 32'(o_synced & o_marker_period_error), 32'h0);
    @(posedge i_core_clk);
    period <= 5'h8;
    @(posedge i_core_clk);
    bad <= 4'hf;
    while (o_sync_error[1] !== 1'b1 && k < 3000) step();
    tmo();
    repeat (30) @(negedge i_core_clk);
    chk("sync err", 32'({o_sync_error[1], o_synced[1], o_block_lock[1]}), 32'h4);
    @(posedge i_core_clk);
    bad <= 4'h0;
    align_wait();
    chk("sync clr", 32'(o_sync_error), 32'h0);
    chk("err clr", 32'({o_marker_period_error, o_marker_repeat_failure}), 32'h0);
    chk("align err clr", 32'(o_aligned_err), 32'h0);
    @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rst_chk();
    results();
  end
endmodule
`default_nettype wire
